// [lbaa_regs.svh]
// Register indices, fields, reset values and timing for the activity alarm
`ifndef LBAA_REGS_SVH
`define LBAA_REGS_SVH
`define LBAA_IDX_SET0 8'h50
`define LBAA_IDX_CLR0 8'h51
`define LBAA_IDX_CEIL0 8'h52
`define LBAA_IDX_LEAK0 8'h53
`define LBAA_IDX_SET1 8'h54
`define LBAA_IDX_CLR1 8'h55
`define LBAA_IDX_CEIL1 8'h56
`define LBAA_IDX_LEAK1 8'h57
`define LBAA_IDX_STATUS 8'h68
`define LBAA_IDX_MASK 8'h69
`define LBAA_IDX_ACCUM0 8'h6A
`define LBAA_IDX_ACCUM1 8'h6B
`define LBAA_IDX_ALARM 8'h6C
`define LBAA_IDX_NONE 8'hFF
`define LBAA_FLD_SET 2'h0
`define LBAA_FLD_CLR 2'h1
`define LBAA_FLD_CEIL 2'h2
`define LBAA_FLD_LEAK 2'h3
`define LBAA_RST_SET 8'h06
`define LBAA_RST_CLR 8'h04
`define LBAA_RST_CEIL 8'h08
`define LBAA_RST_LEAK 2'h1
`define LBAA_RESP_OKAY 2'h0
`define LBAA_RESP_SLVERR 2'h2
`define LBAA_CLK_HZ 25000000
`define LBAA_FILL_MS 128
`define LBAA_FILL_CYC (`LBAA_CLK_HZ / 1000 * `LBAA_FILL_MS)
`endif

// [lbaa_pkg.sv]
// Types shared by the activity alarm modules
package lbaa_pkg;
  typedef struct packed {
    logic [7:0] set_level;
    logic [7:0] clear_level;
    logic [7:0] ceiling;
    logic [1:0] leak_rate;
  } lbaa_cfg_type;
  typedef logic [7:0] lbaa_level_type;
endpackage

// [lbaa_bucket_if.sv]
// Configuration and state of one leaky bucket
`timescale 1ns/1ns
interface lbaa_bucket_if;
  import lbaa_pkg::*;
  lbaa_cfg_type cfg;
  lbaa_level_type accum;
  logic alarm;
  logic alarm_rise;
  logic alarm_fall;
  modport ctrl (output cfg, input accum, alarm, alarm_rise, alarm_fall);
  modport bucket (input cfg, output accum, alarm, alarm_rise, alarm_fall);
endinterface

// [lbaa_bucket.sv]
// One leaky bucket accumulator with hysteretic alarm
`timescale 1ns/1ns
module lbaa_bucket (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fill_tick,
  input wire logic fault_in,
  lbaa_bucket_if.bucket bif
);
  import lbaa_pkg::*;
  logic seen;
  logic [2:0] clean_cnt;
  lbaa_level_type accum;
  logic alarm;
  logic rise;
  logic fall;
  logic next_seen;
  logic [2:0] next_clean_cnt;
  lbaa_level_type next_accum;
  logic next_alarm;
  logic fault_now;
  logic [2:0] period_last;

  assign fault_now = seen | fault_in;
  assign period_last = 3'((4'h1 << bif.cfg.leak_rate) - 4'h1); // [RULE4]

  always_comb begin
    next_seen = fault_now;
    next_clean_cnt = clean_cnt;
    next_accum = accum;
    next_alarm = alarm;
    if (fill_tick) begin // [RULE1]
      next_seen = 1'b0;
      if (fault_now) begin
        next_clean_cnt = 3'h0;
        if (accum < bif.cfg.ceiling) begin
          next_accum = accum + 8'h01; // [RULE2]
        end
      end else if (clean_cnt >= period_last) begin
        next_clean_cnt = 3'h0;
        if (accum != 8'h00) begin
          next_accum = accum - 8'h01; // [RULE3] [RULE9]
        end
      end else begin
        next_clean_cnt = clean_cnt + 3'h1;
      end
      if (next_accum > bif.cfg.ceiling) begin
        next_accum = bif.cfg.ceiling; // [RULE7]
      end
    end
    if (accum >= bif.cfg.set_level) begin
      next_alarm = 1'b1; // [RULE5]
    end else if (accum <= bif.cfg.clear_level) begin
      next_alarm = 1'b0; // [RULE6]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen <= 1'b0;
      clean_cnt <= 3'h0;
      accum <= 8'h00;
      alarm <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      seen <= next_seen;
      clean_cnt <= next_clean_cnt;
      accum <= next_accum;
      alarm <= next_alarm;
      rise <= next_alarm & ~alarm;
      fall <= alarm & ~next_alarm;
    end
  end

  assign bif.accum = accum;
  assign bif.alarm = alarm;
  assign bif.alarm_rise = rise;
  assign bif.alarm_fall = fall;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_accum_tick_only: assert property ( // [RULE1]
    !fill_tick |=> accum == $past(accum))
    else $error("accumulator moved outside a fill tick");
  a_fill_increment: assert property ( // [RULE2]
    fill_tick && fault_now && accum < bif.cfg.ceiling
    |=> accum == $past(accum) + 8'h01)
    else $error("faulty fill cycle did not add one");
  a_leak_decrement: assert property ( // [RULE3]
    fill_tick && !fault_now && clean_cnt == period_last
    && accum != 8'h00 && accum <= bif.cfg.ceiling
    |=> accum == $past(accum) - 8'h01)
    else $error("complete clean period did not remove one");
  a_leak_partial_hold: assert property ( // [RULE4]
    fill_tick && !fault_now && clean_cnt < period_last
    && accum <= bif.cfg.ceiling |=> accum == $past(accum))
    else $error("accumulator leaked before the period ended");
  a_alarm_raise: assert property ( // [RULE5]
    accum >= bif.cfg.set_level |=> alarm)
    else $error("alarm not raised at set level");
  a_alarm_clear: assert property ( // [RULE6]
    accum < bif.cfg.set_level && accum <= bif.cfg.clear_level
    |=> !alarm)
    else $error("alarm not cleared at clear level");
  a_accum_ceiling: assert property ( // [RULE7]
    fill_tick |=> accum <= $past(bif.cfg.ceiling))
    else $error("accumulator above ceiling");
  a_accum_floor: assert property ( // [RULE9]
    fill_tick && accum == 8'h00 && !fault_now |=> accum == 8'h00)
    else $error("accumulator wrapped below zero");
endmodule

// [lbaa_top.sv]
// Leaky bucket activity alarm with AXI4-Lite registers and interrupt
// Functional notes
// RULE1: Evaluate every input once per 128 ms
// RULE2: Faulty fill cycle adds exactly one
// RULE3: Clean period of 1/2/4/8 cycles subtracts one
// RULE4: Leak selector 00..11 gives 128..1024 ms
// RULE5: Alarm raised when accumulator reaches set level
// RULE6: Alarm dropped when accumulator decays to clear
// RULE7: Accumulator saturates at programmed ceiling
// RULE8: Configurations 0 and 1 fully independent
// RULE9: No underflow; clear below set below ceiling
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "lbaa_regs.svh"
module lbaa_top #(
  parameter int ADDR_W = 12,
  parameter int NUM_CFG = 2,
  parameter int FILL_CYC = `LBAA_FILL_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NUM_CFG-1:0] fault_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [NUM_CFG-1:0] alarm,
  output logic irq
);
  import lbaa_pkg::*;

  localparam int CNT_W = $clog2(FILL_CYC);
  localparam int EV_W = 2 * NUM_CFG;

  // Maps a byte address to a register index, or none
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    if (a[ADDR_W-1:10] != '0 || a[1:0] != 2'h0) begin
      return `LBAA_IDX_NONE;
    end
    return a[9:2];
  endfunction

  // Fill cycle divider
  logic [CNT_W-1:0] fill_cnt;
  logic [CNT_W-1:0] next_fill_cnt;
  logic fill_tick;
  logic next_fill_tick;

  always_comb begin
    next_fill_tick = 1'b0;
    next_fill_cnt = fill_cnt + 1'b1;
    if (fill_cnt == CNT_W'(FILL_CYC - 1)) begin
      next_fill_cnt = '0;
      next_fill_tick = 1'b1; // [RULE1]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fill_cnt <= '0;
      fill_tick <= 1'b0;
    end else begin
      fill_cnt <= next_fill_cnt;
      fill_tick <= next_fill_tick;
    end
  end

  // Bucket instances, one per configuration
  lbaa_cfg_type cfg [NUM_CFG];
  logic [EV_W-1:0] events;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CFG; gi++) begin : g_bucket
      lbaa_bucket_if bif ();
      assign bif.cfg = cfg[gi]; // [RULE8]
      assign alarm[gi] = bif.alarm;
      assign events[2*gi] = bif.alarm_rise;
      assign events[2*gi+1] = bif.alarm_fall;
      lbaa_bucket u_bucket (
        .aclk(aclk),
        .aresetn(aresetn),
        .fill_tick(fill_tick),
        .fault_in(fault_in[gi]),
        .bif(bif)
      );
    end
  endgenerate

  lbaa_level_type accum_view [NUM_CFG];
  generate
    for (gi = 0; gi < NUM_CFG; gi++) begin : g_view
      assign accum_view[gi] = g_bucket[gi].bif.accum;
    end
  endgenerate

  // Register file and bus slave state
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_irq;
  logic next_aw_held;
  logic next_w_held;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [7:0] next_w_byte;
  logic next_w_lane;
  logic [EV_W-1:0] next_status;
  logic [EV_W-1:0] next_mask;
  lbaa_cfg_type next_cfg [NUM_CFG];
  logic wr_en;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic [7:0] rel;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic [EV_W-1:0] rd_clear;
  int ci;

  assign wr_en = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx = reg_index(aw_addr);
  assign rd_idx = reg_index(s_axi_araddr);

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_byte = w_byte;
    next_w_lane = w_lane;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_mask = mask;
    next_cfg = cfg;
    rel = 8'h00;
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    rd_clear = '0;
    ci = 0;
    // Address and data are taken independently
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // Write when both halves are held
    if (wr_en) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `LBAA_RESP_OKAY;
      if (wr_idx >= `LBAA_IDX_SET0 && wr_idx <= `LBAA_IDX_LEAK1) begin
        rel = wr_idx - `LBAA_IDX_SET0;
        ci = int'(rel[7:2]);
        if (w_lane) begin
          unique case (rel[1:0])
            `LBAA_FLD_SET: next_cfg[ci].set_level = w_byte; // [RULE8]
            `LBAA_FLD_CLR: next_cfg[ci].clear_level = w_byte;
            `LBAA_FLD_CEIL: next_cfg[ci].ceiling = w_byte;
            `LBAA_FLD_LEAK: next_cfg[ci].leak_rate = w_byte[1:0]; // [RULE8]
          endcase
        end
      end else if (wr_idx == `LBAA_IDX_MASK) begin
        if (w_lane) begin
          next_mask = w_byte[EV_W-1:0];
        end
      end else if (wr_idx != `LBAA_IDX_STATUS) begin
        next_bresp = `LBAA_RESP_SLVERR;
      end
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
    // Read path
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      if (rd_idx >= `LBAA_IDX_SET0 && rd_idx <= `LBAA_IDX_LEAK1) begin
        rel = rd_idx - `LBAA_IDX_SET0;
        ci = int'(rel[7:2]);
        unique case (rel[1:0])
          `LBAA_FLD_SET: rd_byte = cfg[ci].set_level;
          `LBAA_FLD_CLR: rd_byte = cfg[ci].clear_level;
          `LBAA_FLD_CEIL: rd_byte = cfg[ci].ceiling;
          `LBAA_FLD_LEAK: rd_byte = {6'h00, cfg[ci].leak_rate}; // [RULE8]
        endcase
      end else begin
        unique case (rd_idx)
          `LBAA_IDX_STATUS: begin
            rd_byte = 8'(status);
            rd_clear = status;
          end
          `LBAA_IDX_MASK: rd_byte = 8'(mask);
          `LBAA_IDX_ACCUM0: rd_byte = accum_view[0];
          `LBAA_IDX_ACCUM1: rd_byte = accum_view[1];
          `LBAA_IDX_ALARM: rd_byte = 8'(alarm);
          default: rd_hit = 1'b0;
        endcase
      end
      next_rvalid = 1'b1;
      next_rdata = {24'h000000, rd_byte};
      next_rresp = rd_hit ? `LBAA_RESP_OKAY : `LBAA_RESP_SLVERR;
    end
    next_arready = !next_rvalid;
    // Sticky events; a new event wins over the read clear
    next_status = (status & ~rd_clear) | events;
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LBAA_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `LBAA_RESP_OKAY;
      status <= '0;
      mask <= '0;
      irq <= 1'b0;
      for (int i = 0; i < NUM_CFG; i++) begin
        cfg[i].set_level <= `LBAA_RST_SET;
        cfg[i].clear_level <= `LBAA_RST_CLR;
        cfg[i].ceiling <= `LBAA_RST_CEIL;
        cfg[i].leak_rate <= `LBAA_RST_LEAK;
      end
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_byte <= next_w_byte;
      w_lane <= next_w_lane;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      status <= next_status;
      mask <= next_mask;
      irq <= next_irq;
      cfg <= next_cfg;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_cfg_split: assert property ( // [RULE8]
    wr_en && wr_idx == `LBAA_IDX_LEAK0
    |=> cfg[1].leak_rate == $past(cfg[1].leak_rate))
    else $error("configuration 0 write changed configuration 1");
  a_irq_gate: assert property (
    (status & mask) == '0 |-> !irq)
    else $error("interrupt high with no unmasked status");
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_event_sticky: assert property (
    |events |=> (status & $past(events)) == $past(events))
    else $error("alarm event not captured in status");
  // Fill tick, configuration split and leak store checks
  a_tick_period: assert property ( // [RULE1]
    fill_cnt == CNT_W'(FILL_CYC - 1)
    |=> fill_tick && fill_cnt == '0)
    else $error("fill tick missing at end of count");
  a_tick_single: assert property ( // [RULE1]
    fill_tick |=> !fill_tick)
    else $error("fill tick lasted more than one cycle");
  a_cfg_split_back: assert property ( // [RULE8]
    wr_en && wr_idx == `LBAA_IDX_SET1
    |=> cfg[0].set_level == $past(cfg[0].set_level))
    else $error("configuration 1 write changed configuration 0");
  a_leak_store: assert property ( // [RULE8]
    wr_en && w_lane && wr_idx == `LBAA_IDX_LEAK0
    |=> cfg[0].leak_rate == $past(w_byte[1:0]))
    else $error("leak selector not taken from the low two bits");
  // Register bus checks
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_unmapped_write: assert property (
    wr_en && wr_idx == `LBAA_IDX_NONE
    |=> s_axi_bvalid && s_axi_bresp == `LBAA_RESP_SLVERR)
    else $error("unmapped write not refused");
  a_unmapped_read: assert property (
    s_axi_arvalid && s_axi_arready && rd_idx == `LBAA_IDX_NONE
    |=> s_axi_rresp == `LBAA_RESP_SLVERR)
    else $error("unmapped read not refused");
  a_status_clear: assert property (
    s_axi_arvalid && s_axi_arready && rd_idx == `LBAA_IDX_STATUS
    |=> status == $past(events))
    else $error("status read did not clear old events");
endmodule

// [lbaa_top_bench.sv]
// Self-checking bench for the leaky bucket activity alarm
`timescale 1ns/1ns
`include "lbaa_regs.svh"
module lbaa_top_bench;
  import lbaa_pkg::*;
  localparam int FC = 64;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [1:0] fault_in = 2'h0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, alarm;
  logic [31:0] rdata;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int seed = 32'he5fe;
  int mcnt, macc[2], mcln[2], mset[2], mclr[2], mceil[2], mleak[2];
  logic [3:0] mstat, mmask;
  logic [1:0] malm, mflt;
  always #20 aclk = ~aclk;
  lbaa_top #(.FILL_CYC(FC)) uut (
    .aclk(aclk), .aresetn(aresetn), .fault_in(fault_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .alarm(alarm), .irq(irq)
  );
  task final_report;
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Reference model of both buckets, ticking every FC cycles
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc > 20000) begin
      n_fail++;
      final_report();
    end
    if (!aresetn) begin
      mcnt = 0;
      mstat = 4'h0;
      mmask = 4'h0;
      malm = 2'h0;
      mflt = 2'h0;
      for (int i = 0; i < 2; i++) begin
        macc[i] = 0;
        mcln[i] = 0;
        mset[i] = `LBAA_RST_SET;
        mclr[i] = `LBAA_RST_CLR;
        mceil[i] = `LBAA_RST_CEIL;
        mleak[i] = `LBAA_RST_LEAK;
      end
    end else begin
      mflt = mflt | fault_in;
      mcnt = mcnt + 1;
      if (mcnt == FC) begin
        mcnt = 0;
        for (int i = 0; i < 2; i++) begin
          if (mflt[i]) begin
            macc[i] = macc[i] + 1;
            mcln[i] = 0;
          end else begin
            mcln[i] = mcln[i] + 1;
            if (mcln[i] >= (1 << mleak[i])) begin
              mcln[i] = 0;
              if (macc[i] > 0) macc[i] = macc[i] - 1;
            end
          end
          if (macc[i] > mceil[i]) macc[i] = mceil[i];
          if (macc[i] >= mset[i] && !malm[i]) begin
            malm[i] = 1'b1;
            mstat[2*i] = 1'b1;
          end else if (macc[i] <= mclr[i] && malm[i]) begin
            malm[i] = 1'b0;
            mstat[2*i+1] = 1'b1;
          end
        end
        mflt = 2'h0;
      end
    end
  end
  function automatic int rnd(int n);
    return $unsigned($random(seed)) % n;
  endfunction
  function automatic logic [31:0] mreg(int k);
    int c;
    c = (k >> 2) & 1;
    case (k)
      `LBAA_IDX_STATUS: return mstat;
      `LBAA_IDX_MASK: return mmask;
      `LBAA_IDX_ACCUM0: return macc[0];
      `LBAA_IDX_ACCUM1: return macc[1];
      `LBAA_IDX_ALARM: return malm;
      default: begin
        case (k & 3)
          0: return mset[c];
          1: return mclr[c];
          2: return mceil[c];
          default: return mleak[c];
        endcase
      end
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    checks++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    int t = 0;
    int dly;
    dly = rnd(4);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= (dly == 0);
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      t++;
      if (t == dly) bready <= 1'b1;
    end while (!(bvalid && bready) && t < 50);
    r = bresp;
    bready <= 1'b0;
    if (t >= 50) begin
      n_fail++;
      final_report();
    end
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int t = 0;
    int dly;
    dly = rnd(4);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (dly == 0);
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      t++;
      if (t == dly) rready <= 1'b1;
    end while (!(rvalid && rready) && t < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (t >= 50) begin
      n_fail++;
      final_report();
    end
  endtask
  task automatic rchk(input int k);
    logic [31:0] e, d;
    logic [1:0] r;
    e = mreg(k);
    rd(12'(k * 4), d, r);
    if (k == `LBAA_IDX_STATUS) mstat = 4'h0;
    chk("rresp", `LBAA_RESP_OKAY, r);
    chk("rdata", e, d);
  endtask
  task automatic wcfg(input int k, input logic [31:0] d);
    logic [1:0] r;
    int c;
    c = (k >> 2) & 1;
    wr(12'(k * 4), d, 4'hF, r);
    chk("bresp", `LBAA_RESP_OKAY, r);
    if (k == `LBAA_IDX_MASK) mmask = d[3:0];
    else if ((k & 3) == 0) mset[c] = d[7:0];
    else if ((k & 3) == 1) mclr[c] = d[7:0];
    else if ((k & 3) == 2) mceil[c] = d[7:0];
    else mleak[c] = d[1:0];
  endtask
  task automatic sync;
    int t = 0;
    do begin
      @(posedge aclk);
      t++;
    end while (mcnt != FC / 4 && t < 2 * FC);
  endtask
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    int cl, st;
    for (int run = 0; run < 5; run++) begin
      aresetn <= 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      sync();
      for (int k = 'h50; k <= 'h6C; k++)
        if (k <= 'h57 || k >= 'h68) rchk(k);
      sync();
      if (run == 0) begin
        wr(4 * `LBAA_IDX_SET0, 32'h11, 4'h0, r);
        chk("bresp", `LBAA_RESP_OKAY, r);
        wr(4 * `LBAA_IDX_STATUS, 32'hF, 4'hF, r);
        chk("bresp", `LBAA_RESP_OKAY, r);
        wr(12'h3FC, 32'h1, 4'hF, r);
        chk("bresp", `LBAA_RESP_SLVERR, r);
        rd(12'h141, d, r);
        chk("rresp", `LBAA_RESP_SLVERR, r);
        rd(12'h1FC, d, r);
        chk("rresp", `LBAA_RESP_SLVERR, r);
      end else begin
        for (int c = 0; c < 2; c++) begin
          cl = 6 + rnd(10);
          st = 3 + rnd(cl - 2);
          wcfg('h52 + 4 * c, cl);
          wcfg('h50 + 4 * c, st);
          wcfg('h51 + 4 * c, rnd(st));
        end
        sync();
        wcfg(`LBAA_IDX_LEAK0, ($random(seed) & ~3) | (run - 1));
        wcfg(`LBAA_IDX_LEAK1, ($random(seed) & ~3) | (4 - run));
      end
      wcfg(`LBAA_IDX_MASK, $random(seed) & 15);
      for (int p = 0; p < 24; p++) begin
        sync();
        fault_in[0] <= rnd(8) < (p < 12 ? 6 : 1);
        fault_in[1] <= rnd(8) < (p < 12 ? 5 : 1);
        @(posedge aclk);
        fault_in <= 2'h0;
        chk("alarm", malm, alarm);
        chk("irq", |(mstat & mmask), irq);
        rchk(`LBAA_IDX_ACCUM0);
        rchk(`LBAA_IDX_ACCUM1);
        rchk(`LBAA_IDX_STATUS);
        rchk(`LBAA_IDX_ALARM);
      end
      sync();
      for (int k = 'h50; k <= 'h57; k++) rchk(k);
      rchk(`LBAA_IDX_MASK);
    end
    final_report();
  end
endmodule
